// ==== rtl/mirq_map.svh ====
`ifndef MIRQ_MAP_SVH
`define MIRQ_MAP_SVH
`define MIRQ_A_CTRL 3'h0
`define MIRQ_A_OPT 3'h1
`define MIRQ_A_PF1 3'h2
`define MIRQ_A_PF2 3'h3
`define MIRQ_A_PM1 3'h4
`define MIRQ_A_PM2 3'h5
`define MIRQ_B_GIE 7
`define MIRQ_B_PIE 6
`define MIRQ_B_T0M 5
`define MIRQ_B_EXM 4
`define MIRQ_B_PCM 3
`define MIRQ_B_T0F 2
`define MIRQ_B_EXF 1
`define MIRQ_B_PCF 0
`define MIRQ_B_EDGE 6
`define MIRQ_VECTOR 13'h0004
`define MIRQ_CTRL_RST 8'h00
`define MIRQ_OPT_RST 8'hff
`define MIRQ_PF_RST 8'h00
`define MIRQ_T0_MAX 8'hff
`define MIRQ_T0_MIN 8'h00
`define MIRQ_LAT_CYC 2'h2
`endif

// ==== rtl/mirq_pkg.sv ====
package mirq_pkg;
	typedef logic [7:0]  mirq_byte_t;
	typedef logic [12:0] mirq_pc_t;
	typedef enum logic [1:0] {
		MIRQ_RUN,
		MIRQ_WAIT,
		MIRQ_HALT
	} mirq_state_t;
endpackage : mirq_pkg

// ==== rtl/mirq_ext_det.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mirq_map.svh"
// ==========================================
// Edge detector for the external pin and port-change detector
module mirq_ext_det (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	// Pins
	input  wire logic       ext_irq_pin_in,
	input  wire logic [3:0] upper_port_pins_in,
	input  wire logic       edge_rise_in,
	// Events
	output logic            ext_evt_out,
	output logic            port_evt_out
);
	logic       pin_r;
	logic [3:0] port_r;
	logic       seen_r;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pin_r  <= 1'b0;
			port_r <= 4'h0;
			seen_r <= 1'b0;
		end else begin
			pin_r  <= ext_irq_pin_in;
			port_r <= upper_port_pins_in;
			seen_r <= 1'b1;
		end
	end

	// Select rising or falling edge
	assign ext_evt_out = seen_r & (edge_rise_in ?
		(ext_irq_pin_in & ~pin_r) : (~ext_irq_pin_in & pin_r));
	assign port_evt_out = seen_r & (|(upper_port_pins_in ^ port_r));
endmodule : mirq_ext_det
`default_nettype wire

// ==== rtl/mirq_flags.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mirq_map.svh"
// ==========================================
// Byte of sticky request flags; hardware set beats software write
module mirq_flags (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	// Software write
	input  wire logic       wr_in,
	input  wire logic [7:0] wdata_in,
	// Hardware sets
	input  wire logic [7:0] set_in,
	// State
	output logic [7:0]      flags_out
);
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			flags_out <= `MIRQ_PF_RST;
		else if (wr_in)
			flags_out <= wdata_in | set_in;
		else
			flags_out <= flags_out | set_in;
	end
endmodule : mirq_flags
`default_nettype wire

// ==== rtl/mirq_irq_logic.sv ====
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "mirq_map.svh"
// ==========================================
// Interrupt logic: flags, masks, enables, vectoring and wake
module mirq_irq_logic (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             nrst_in,
	// Register port
	input  wire logic [2:0]       addr_in,
	input  wire mirq_pkg::mirq_byte_t wdata_in,
	input  wire logic             wr_in,
	input  wire logic             rd_in,
	output mirq_pkg::mirq_byte_t  rdata_out,
	// Sources
	input  wire logic             ext_irq_pin_in,
	input  wire logic [3:0]       upper_port_pins_in,
	input  wire mirq_pkg::mirq_byte_t timer0_count_in,
	input  wire mirq_pkg::mirq_byte_t periph1_evt_in,
	input  wire mirq_pkg::mirq_byte_t periph2_evt_in,
	// Core sequencer
	input  wire logic             instr_end_in,
	input  wire logic             return_from_irq_in,
	input  wire logic             halt_in,
	input  wire mirq_pkg::mirq_pc_t return_pc_in,
	output logic                  vector_out,
	output mirq_pkg::mirq_pc_t    vector_pc_out,
	output logic                  push_out,
	output mirq_pkg::mirq_pc_t    push_pc_out,
	output logic                  halted_out,
	output logic                  wake_out
);
	import mirq_pkg::*;

	mirq_byte_t  ctrl_r;
	mirq_byte_t  opt_r;
	mirq_byte_t  pm1_r;
	mirq_byte_t  pm2_r;
	mirq_byte_t  pf1;
	mirq_byte_t  pf2;
	mirq_byte_t  t0_prev_r;
	mirq_state_t state_r;
	logic [1:0]  lat_r;
	logic        ext_evt;
	logic        port_evt;
	logic        t0_evt;
	logic        pend;
	logic        take;
	logic        wr_ctrl;

	function automatic logic dec(input logic [2:0] a, input logic [2:0] b);
		dec = (a == b);
	endfunction : dec

	// ==========================================
	// Source detection
	mirq_ext_det u_det (
		.clk_in             (clk_in),
		.nrst_in            (nrst_in),
		.ext_irq_pin_in     (ext_irq_pin_in),
		.upper_port_pins_in (upper_port_pins_in),
		.edge_rise_in       (opt_r[`MIRQ_B_EDGE]),
		.ext_evt_out        (ext_evt),
		.port_evt_out       (port_evt)
	);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			t0_prev_r <= `MIRQ_T0_MIN;
		else
			t0_prev_r <= timer0_count_in;
	end

	assign t0_evt = (t0_prev_r == `MIRQ_T0_MAX) &&
		(timer0_count_in == `MIRQ_T0_MIN);

	// ==========================================
	// Peripheral flags
	mirq_flags u_pf1 (
		.clk_in    (clk_in),
		.nrst_in   (nrst_in),
		.wr_in     (wr_in && dec(addr_in, `MIRQ_A_PF1)),
		.wdata_in  (wdata_in),
		.set_in    (periph1_evt_in),
		.flags_out (pf1)
	);

	mirq_flags u_pf2 (
		.clk_in    (clk_in),
		.nrst_in   (nrst_in),
		.wr_in     (wr_in && dec(addr_in, `MIRQ_A_PF2)),
		.wdata_in  (wdata_in),
		.set_in    (periph2_evt_in),
		.flags_out (pf2)
	);

	// ==========================================
	// Control register
	assign wr_ctrl = wr_in && dec(addr_in, `MIRQ_A_CTRL);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_r <= `MIRQ_CTRL_RST;
		end else begin
			if (wr_ctrl)
				ctrl_r <= wdata_in;
			if (take)
				ctrl_r[`MIRQ_B_GIE] <= 1'b0;
			else if (return_from_irq_in)
				ctrl_r[`MIRQ_B_GIE] <= 1'b1;
			// Hardware sets override a same-cycle clear
			if (ext_evt)
				ctrl_r[`MIRQ_B_EXF] <= 1'b1;
			if (t0_evt)
				ctrl_r[`MIRQ_B_T0F] <= 1'b1;
			if (port_evt)
				ctrl_r[`MIRQ_B_PCF] <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			opt_r <= `MIRQ_OPT_RST;
			pm1_r <= `MIRQ_PF_RST;
			pm2_r <= `MIRQ_PF_RST;
		end else if (wr_in) begin
			if (dec(addr_in, `MIRQ_A_OPT))
				opt_r <= wdata_in;
			if (dec(addr_in, `MIRQ_A_PM1))
				pm1_r <= wdata_in;
			if (dec(addr_in, `MIRQ_A_PM2))
				pm2_r <= wdata_in;
		end
	end

	// ==========================================
	// Pending request: flag and mask, peripherals gated
	assign pend =
		(ctrl_r[`MIRQ_B_EXF] & ctrl_r[`MIRQ_B_EXM]) |
		(ctrl_r[`MIRQ_B_T0F] & ctrl_r[`MIRQ_B_T0M]) |
		(ctrl_r[`MIRQ_B_PCF] & ctrl_r[`MIRQ_B_PCM]) |
		(ctrl_r[`MIRQ_B_PIE] & (|(pf1 & pm1_r) | |(pf2 & pm2_r)));

	// ==========================================
	// Sequencing: fixed latency, wake from halt
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_r <= MIRQ_RUN;
			lat_r   <= 2'h0;
		end else begin
			unique case (state_r)
				MIRQ_RUN: begin
					if (pend && ctrl_r[`MIRQ_B_GIE]) begin
						state_r <= MIRQ_WAIT;
						lat_r   <= 2'h0;
					end else if (halt_in) begin
						state_r <= MIRQ_HALT;
					end
				end
				MIRQ_WAIT: begin
					if (!ctrl_r[`MIRQ_B_GIE] || !pend)
						state_r <= MIRQ_RUN;
					else if (take)
						state_r <= MIRQ_RUN;
					else if (lat_r != `MIRQ_LAT_CYC)
						lat_r <= lat_r + 2'h1;
				end
				MIRQ_HALT: begin
					if (pend)
						state_r <= MIRQ_RUN;
				end
				default: state_r <= MIRQ_RUN;
			endcase
		end
	end

	// Vector once the fixed latency has run and an instruction ends
	assign take = (state_r == MIRQ_WAIT) && ctrl_r[`MIRQ_B_GIE] && pend &&
		(lat_r == `MIRQ_LAT_CYC) && instr_end_in;

	assign halted_out = (state_r == MIRQ_HALT);
	assign wake_out   = (state_r == MIRQ_HALT) && pend;

	// ==========================================
	// Outputs to core: only the return address is pushed
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			vector_out    <= 1'b0;
			push_out      <= 1'b0;
			vector_pc_out <= 13'h0000;
			push_pc_out   <= 13'h0000;
		end else begin
			vector_out    <= take;
			push_out      <= take;
			vector_pc_out <= `MIRQ_VECTOR;
			if (take)
				push_pc_out <= return_pc_in;
		end
	end

	// ==========================================
	// Register read, one cycle later
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			unique case (addr_in)
				`MIRQ_A_CTRL: rdata_out <= ctrl_r;
				`MIRQ_A_OPT:  rdata_out <= opt_r;
				`MIRQ_A_PF1:  rdata_out <= pf1;
				`MIRQ_A_PF2:  rdata_out <= pf2;
				`MIRQ_A_PM1:  rdata_out <= pm1_r;
				`MIRQ_A_PM2:  rdata_out <= pm2_r;
				default:      rdata_out <= 8'h00;
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end
endmodule : mirq_irq_logic
`default_nettype wire

// ==== sim/mirq_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Core sequencer and timer stand-in
module mirq_core_model (
	// Clock and reset
	input	wire logic	clk_in,
	input	wire logic	nrst_in,
	// Timer run request
	input	wire logic	run_in,
	// To the block
	output	logic	instr_end_out,
	output	mirq_pkg::mirq_pc_t	return_pc_out,
	output	mirq_pkg::mirq_byte_t	timer0_count_out
);
	import mirq_pkg::*;
	mirq_byte_t	timer_r;
	assign instr_end_out = 1'b1;
	assign return_pc_out = 13'h0a5c;
	assign timer0_count_out = timer_r;
	// Counts only on request so the wrap lands where a test wants it
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			timer_r <= 8'hf8;
		else if (run_in)
			timer_r <= timer_r + 8'h01;
	end
endmodule : mirq_core_model
`default_nettype wire

// ==== sim/mirq_irq_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checker
module mirq_irq_monitor (
	input	wire logic	clk_in,
	input	wire logic	nrst_in,
	input	wire logic	rd_in,
	input	wire mirq_pkg::mirq_byte_t	rdata_out,
	input	wire mirq_pkg::mirq_pc_t	return_pc_in,
	input	wire logic	vector_out,
	input	wire mirq_pkg::mirq_pc_t	vector_pc_out,
	input	wire logic	push_out,
	input	wire mirq_pkg::mirq_pc_t	push_pc_out,
	input	wire logic	halted_out,
	input	wire logic	wake_out
);
	import mirq_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	chk_vec_addr: assert property (
		vector_out |-> vector_pc_out == 13'h0004) else $error("bad vector");
	chk_push_pair: assert property (
		vector_out == push_out) else $error("push apart from vector");
	chk_push_addr: assert property (
		push_out |-> push_pc_out == $past(return_pc_in))
		else $error("bad push address");
	chk_vec_once: assert property (
		vector_out |=> !vector_out [*4]) else $error("vector repeated");
	chk_rd_quiet: assert property (
		!$past(rd_in) |-> rdata_out == 8'h00) else $error("stray read data");
	chk_wake_halt: assert property (
		wake_out |-> halted_out) else $error("wake while running");
	chk_wake_run: assert property (
		wake_out |=> !halted_out) else $error("wake did not resume");
	chk_halt_hold: assert property (
		halted_out && !wake_out |=> halted_out) else $error("halt left");
	cover property (vector_out);
	cover property (wake_out);
	cover property ($past(rd_in) && rdata_out != 8'h00);
endmodule : mirq_irq_monitor
bind mirq_irq_logic mirq_irq_monitor u_mon (.clk_in, .nrst_in, .rd_in,
	.rdata_out, .return_pc_in, .vector_out, .vector_pc_out, .push_out,
	.push_pc_out, .halted_out, .wake_out);
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Testbench
module tb;
	import mirq_pkg::*;
	logic	clk_in, nrst_in, wr_in, rd_in, pin, rfi, halt, run, rd_d;
	logic	iend, vec, push, halted, wake;
	logic [2:0]	addr_in;
	logic [3:0]	up;
	mirq_byte_t	wdata_in, rdata_out, tmr, p1, p2, rnd;
	mirq_pc_t	rpc, vpc, ppc;
	int	n_errors, comparisons, cyc, edge_cyc;
	mirq_byte_t	rq[$];
	int	vq[$];
	mirq_irq_logic u_dut (.clk_in(clk_in), .nrst_in(nrst_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .ext_irq_pin_in(pin), .upper_port_pins_in(up),
		.timer0_count_in(tmr), .periph1_evt_in(p1), .periph2_evt_in(p2),
		.instr_end_in(iend), .return_from_irq_in(rfi), .halt_in(halt),
		.return_pc_in(rpc), .vector_out(vec), .vector_pc_out(vpc),
		.push_out(push), .push_pc_out(ppc), .halted_out(halted),
		.wake_out(wake));
	mirq_core_model u_core (.clk_in(clk_in), .nrst_in(nrst_in), .run_in(run),
		.instr_end_out(iend), .return_pc_out(rpc), .timer0_count_out(tmr));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out
	task automatic bad(input logic [31:0] got, input logic [31:0] exp);
		n_errors++;
		$display("unexpected at %0t: got %h expected %h", $time, got, exp);
	endtask : bad
	task automatic cmp_rd(input mirq_byte_t exp);
		comparisons++;
		if (rdata_out !== exp) bad(rdata_out, exp);
	endtask : cmp_rd
	task automatic cmp_vec(input int exp);
		comparisons++;
		if (exp == -1 || (exp >= 0 && cyc - edge_cyc != exp))
			bad(cyc - edge_cyc, exp);
	endtask : cmp_vec
	task automatic cmp_lvl(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) bad(got, exp);
	endtask : cmp_lvl
	task automatic cmp_pc(input mirq_pc_t got, input mirq_pc_t exp);
		comparisons++;
		if (got !== exp) bad(got, exp);
	endtask : cmp_pc
	// Timeout, read and vector watcher
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		rd_d <= rd_in;
		if (cyc > 2000) begin
			n_errors++;
			close_out();
		end
	end
	always @(negedge clk_in) begin
		if (rd_d === 1'b1) cmp_rd(rq.pop_front());
		if (vec === 1'b1) cmp_vec(vq.size() > 0 ? vq.pop_front() : -1);
		if (vec === 1'b1) cmp_pc(vpc, 13'h0004);
		if (vec === 1'b1) cmp_pc(ppc, 13'h0a5c);
		if (vec === 1'b1) cmp_lvl(push, 1'b1);
	end
	task automatic wr(input logic [2:0] a, input mirq_byte_t d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input mirq_byte_t exp);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		rq.push_back(exp);
		@(posedge clk_in);
		rd_in <= 1'b0;
	endtask : rd
	task automatic halt_wake(input mirq_byte_t ctrl);
		wr(3'h0, ctrl);
		@(posedge clk_in);
		halt <= 1'b1;
		pin <= 1'b1;
		@(posedge clk_in);
		halt <= 1'b0;
		@(negedge clk_in);
		cmp_lvl(halted, 1'b1);
		@(posedge clk_in);
		pin <= 1'b0;
		for (int i = 0; i < 10 && wake !== 1'b1; i++) @(negedge clk_in);
		cmp_lvl(wake, 1'b1);
	endtask : halt_wake
	initial begin
		{nrst_in, wr_in, rd_in, addr_in, wdata_in, pin, up} = '0;
		{p1, p2, rfi, halt, run, edge_cyc, n_errors, comparisons} = '0;
		void'($urandom(32'hfb078589));
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		for (int a = 0; a < 7; a++) rd(a[2:0], a == 1 ? 8'hff : 8'h00);
		$display("reset values done");
		rnd = mirq_byte_t'($urandom());
		@(posedge clk_in);
		{pin, up, p1, p2, run} <= {1'b1, 4'h5, rnd, ~rnd, 1'b1};
		@(posedge clk_in);
		{p1, p2} <= 16'h0000;
		repeat (12) @(posedge clk_in);
		run <= 1'b0;
		rd(3'h0, 8'h07);
		rd(3'h2, rnd);
		rd(3'h3, ~rnd);
		$display("masked sources done");
		@(posedge clk_in);
		{addr_in, wdata_in, wr_in, p1} <= {3'h2, 8'h00, 1'b1, 8'h81};
		@(posedge clk_in);
		{wr_in, p1} <= 9'h000;
		rd(3'h2, 8'h81);
		wr(3'h1, 8'hbf);
		wr(3'h0, 8'h00);
		@(posedge clk_in);
		pin <= 1'b0;
		rd(3'h0, 8'h02);
		wr(3'h0, 8'h10);
		@(posedge clk_in);
		pin <= 1'b1;
		rd(3'h0, 8'h10);
		$display("edge select done");
		@(posedge clk_in);
		pin <= 1'b0;
		repeat (8) @(posedge clk_in);
		rd(3'h0, 8'h12);
		wr(3'h0, 8'h90);
		@(posedge clk_in);
		pin <= 1'b1;
		@(posedge clk_in);
		pin <= 1'b0;
		vq.push_back(5);
		@(negedge clk_in);
		edge_cyc = cyc;
		repeat (8) @(posedge clk_in);
		rd(3'h0, 8'h12);
		wr(3'h0, 8'h10);
		@(posedge clk_in);
		rfi <= 1'b1;
		@(posedge clk_in);
		rfi <= 1'b0;
		rd(3'h0, 8'h90);
		$display("vectoring done");
		halt_wake(8'h10);
		repeat (8) @(posedge clk_in);
		@(negedge clk_in);
		cmp_lvl(halted, 1'b0);
		rd(3'h0, 8'h12);
		vq.push_back(-2);
		halt_wake(8'h90);
		repeat (12) @(posedge clk_in);
		cmp_lvl(vq.size() == 0, 1'b1);
		$display("halt wake done");
		wr(3'h0, 8'h00);
		wr(3'h4, 8'h01);
		wr(3'h0, 8'h80);
		repeat (8) @(posedge clk_in);
		rd(3'h0, 8'h80);
		vq.push_back(4);
		wr(3'h0, 8'hc0);
		@(negedge clk_in);
		edge_cyc = cyc;
		repeat (8) @(posedge clk_in);
		rd(3'h0, 8'h40);
		wr(3'h0, 8'h88);
		@(posedge clk_in);
		up <= ~up;
		vq.push_back(5);
		@(negedge clk_in);
		edge_cyc = cyc;
		repeat (8) @(posedge clk_in);
		rd(3'h0, 8'h09);
		cmp_lvl(vq.size() == 0, 1'b1);
		$display("peripheral and port vectoring done");
		close_out();
	end
endmodule : tb
`default_nettype wire
